/* hw/adc_serial_scan_control.v */
`timescale 1ns/10ps
`include "adc_scan_map.vh"
module adc_serial_scan_control #(
    parameter TEN_BIT = 0
) (
    input wire clk_sys,
    input wire rst,
    input wire sclk,
    input wire cs_n,
    input wire din,
    input wire conversion_start_n,
    input wire [11:0] analog_code,
    input wire analog_negative,
    output reg dout,
    output reg dout_oe,
    output reg eoc_n,
    output reg sample_strobe,
    output reg [3:0] conv_channel,
    output reg analog_awake,
    output reg common_reference,
    output reg software_convert,
    output reg channel_tag_enable,
    output reg [3:0] fifo_count
);
    localparam ST_IDLE = 3'b001;
    localparam ST_DELAY = 3'b010;
    localparam ST_CONV = 3'b100;
    localparam integer CONV_CYC = `CONV_SYS_CYCLES;
    localparam integer SOFTWARE_CONVERT_CYC = `SOFTWARE_CONVERT_SYS_CYCLES;

    // Result coding; the analog core hands over offset binary and a sign flag.
    function [11:0] code_result;
        input [11:0] raw;
        input neg;
        input bipolar;
        reg [11:0] c;
        begin
            if (bipolar)
                c = {~raw[11], raw[10:0]};
            else if (neg)
                c = 12'h000;
            else
                c = raw;
            if (TEN_BIT != 0)
                c = {c[11:2], 2'b00};
            code_result = c;
        end
    endfunction

    // Output word layout for the serial port.
    function [15:0] out_word;
        input [3:0] ch;
        input [11:0] res;
        input tag;
        begin
            if (tag)
                out_word = {ch, res};
            else
                out_word = {1'b0, res, 3'b000};
        end
    endfunction

    // Two-flop synchronisers; only the second stage is read by logic.
    reg [1:0] sclk_s_r, cs_s_r, din_s_r, cnv_s_r;
    reg sclk_d_r, cs_d_r, cnv_d_r;
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sclk_s_r <= 2'b11;
            cs_s_r <= 2'b11;
            din_s_r <= 2'b00;
            cnv_s_r <= 2'b11;
            sclk_d_r <= 1'b1;
            cs_d_r <= 1'b1;
            cnv_d_r <= 1'b1;
        end else begin
            sclk_s_r <= {sclk_s_r[0], sclk};
            cs_s_r <= {cs_s_r[0], cs_n};
            din_s_r <= {din_s_r[0], din};
            cnv_s_r <= {cnv_s_r[0], conversion_start_n};
            sclk_d_r <= sclk_s_r[1];
            cs_d_r <= cs_s_r[1];
            cnv_d_r <= cnv_s_r[1];
        end
    end

    wire cs_low = ~cs_s_r[1];
    wire cs_fall = cs_d_r & ~cs_s_r[1];
    wire cs_rise = ~cs_d_r & cs_s_r[1];
    wire sclk_rise = cs_low & ~sclk_d_r & sclk_s_r[1];
    wire sclk_fall = cs_low & sclk_d_r & ~sclk_s_r[1];
    wire cnv_fall = cnv_d_r & ~cnv_s_r[1];
    wire cnv_rise = ~cnv_d_r & cnv_s_r[1];

    // Configuration state written through command words.
    reg [3:0] scan_r;
    reg [3:0] chan_r;
    reg [7:0] bipolar_r;
    reg [7:0] pairs_r;
    reg [1:0] pdiff_r;
    wire internal_mode = (scan_r == `SCAN_STD_INT);

    // Serial side: command receive, transmit shifter and held external result.
    reg [15:0] cmd_r;
    reg [4:0] bits_r;
    reg [15:0] tx_r;
    reg [3:0] tx_left_r;
    reg [3:0] ext_ch_r;
    reg [11:0] ext_res_r;
    reg ext_valid_r;

    // Result FIFO.
    reg [15:0] fifo_mem [0:`FIFO_DEPTH-1];
    reg [3:0] rd_ptr_r, wr_ptr_r;
    reg [4:0] cnt_r;
    wire fifo_empty = (cnt_r == 5'h00);
    wire fifo_full = (cnt_r == 5'h10);

    // Scan engine.
    reg [2:0] state_r;
    reg [7:0] timer_r;
    reg [3:0] scan_ch_r;
    reg push_r;

    // A word loaded after sixteen falls leaves the FIFO only once its first bit
    // goes out, so a frame of exactly sixteen bits loses no stored result.
    reg pend_pop_r;
    wire pop = ~fifo_empty & internal_mode & (cs_fall | (sclk_fall & pend_pop_r));
    wire pair_diff = pairs_r[conv_channel[3:1]];
    wire pair_bip = bipolar_r[conv_channel[3:1]] & pair_diff;
    wire [11:0] coded = code_result(analog_code, analog_negative, pair_bip);
    wire cmd_done = cs_rise & (bits_r >= `WORD_BITS);
    wire soft_rst = cmd_done & ~cmd_r[`CMD_TARGET_BIT]
        & (cmd_r[`CMD_RESET_HI:`CMD_RESET_LO] == `SOFT_RESET_CODE);
    // The frame that writes the software start also arms it at its own end.
    wire sw_take = cmd_done & ~cmd_r[`CMD_TARGET_BIT] & (bits_r >= `SOFTWARE_CONVERT_HOLD_BITS)
        & cmd_r[`CMD_SOFTWARE_CONVERT_BIT];

    // Command capture on rising clock edges; the word is decoded at frame end.
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cmd_r <= 16'h0000;
            bits_r <= 5'h00;
        end else if (cs_fall) begin
            bits_r <= 5'h00;
        end else if (sclk_rise) begin
            if (bits_r < `WORD_BITS)
                cmd_r <= {cmd_r[14:0], din_s_r[1]};
            if (bits_r != 5'h1F)
                bits_r <= bits_r + 5'h01;
        end
    end

    // Register writes. Bit 15 picks mode control or a configuration target.
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            scan_r <= `RST_SCAN;
            chan_r <= `RST_CHAN;
            bipolar_r <= `RST_PAIRS;
            pairs_r <= `RST_PAIRS;
            pdiff_r <= `RST_PDIFF;
            channel_tag_enable <= 1'b0;
        end else if (soft_rst) begin
            scan_r <= `RST_SCAN;
            chan_r <= `RST_CHAN;
            bipolar_r <= `RST_PAIRS;
            pairs_r <= `RST_PAIRS;
            pdiff_r <= `RST_PDIFF;
            channel_tag_enable <= 1'b0;
        end else if (cmd_done) begin
            if (!cmd_r[`CMD_TARGET_BIT]) begin
                scan_r <= cmd_r[`CMD_SCAN_HI:`CMD_SCAN_LO];
                chan_r <= cmd_r[`CMD_CHAN_HI:`CMD_CHAN_LO];
                channel_tag_enable <= cmd_r[`CMD_TAG_BIT];
            end else if (cmd_r[`CMD_SEL_HI:`CMD_SEL_LO] == `SEL_UNIPOLAR) begin
                pairs_r <= cmd_r[`CMD_DATA_HI:`CMD_DATA_LO];
                pdiff_r <= cmd_r[`CMD_PDIFF_HI:`CMD_PDIFF_LO];
            end else if (cmd_r[`CMD_SEL_HI:`CMD_SEL_LO] == `SEL_BIPOLAR) begin
                bipolar_r <= cmd_r[`CMD_DATA_HI:`CMD_DATA_LO];
                pairs_r <= cmd_r[`CMD_DATA_HI:`CMD_DATA_LO];
            end
        end
    end

    // Transmit shifter. In internal mode words reload every sixteen falling edges so a long
    // frame walks through the FIFO oldest first.
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            tx_r <= 16'h0000;
            tx_left_r <= 4'h0;
            pend_pop_r <= 1'b0;
            dout <= 1'b0;
            dout_oe <= 1'b0;
        end else begin
            dout_oe <= cs_low & ~cs_fall;
            if (cs_fall) begin
                tx_left_r <= 4'h0;
                pend_pop_r <= 1'b0;
                dout <= 1'b0;
                if (internal_mode)
                    tx_r <= fifo_empty ? 16'h0000 : fifo_mem[rd_ptr_r];
                else if (ext_valid_r)
                    tx_r <= out_word(ext_ch_r, ext_res_r, channel_tag_enable);
                else
                    tx_r <= 16'h0000;
            end else if (sclk_fall) begin
                dout <= tx_r[15];
                tx_left_r <= tx_left_r - 4'h1;
                if (tx_left_r == 4'h1 && internal_mode) begin
                    tx_r <= fifo_empty ? 16'h0000 : fifo_mem[rd_ptr_r];
                    pend_pop_r <= ~fifo_empty;
                end else begin
                    tx_r <= {tx_r[14:0], 1'b0};
                    pend_pop_r <= 1'b0;
                end
            end
        end
    end

    // External clock: the frame edge samples the channel chosen last frame and
    // the result is held for the next frame.
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ext_ch_r <= 4'h0;
            ext_res_r <= 12'h000;
            ext_valid_r <= 1'b0;
        end else if (soft_rst) begin
            ext_valid_r <= 1'b0;
        end else if (cs_rise & ~internal_mode) begin
            ext_ch_r <= conv_channel;
            ext_res_r <= coded;
            ext_valid_r <= 1'b1;
        end
    end

    // FIFO pointers. A push into a full FIFO drops the oldest entry.
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rd_ptr_r <= 4'h0;
            wr_ptr_r <= 4'h0;
            cnt_r <= 5'h00;
        end else if (soft_rst) begin
            rd_ptr_r <= 4'h0;
            wr_ptr_r <= 4'h0;
            cnt_r <= 5'h00;
        end else begin
            if (push_r)
                wr_ptr_r <= wr_ptr_r + 4'h1;
            if (push_r & fifo_full)
                rd_ptr_r <= rd_ptr_r + 4'h1;
            else if (pop)
                rd_ptr_r <= rd_ptr_r + 4'h1;
            if (push_r & ~fifo_full & ~pop)
                cnt_r <= cnt_r + 5'h01;
            else if (pop & ~push_r)
                cnt_r <= cnt_r - 5'h01;
        end
    end

    // FIFO storage has no reset; the count guards stale words.
    always @(posedge clk_sys) begin
        if (push_r)
            fifo_mem[wr_ptr_r] <= {conv_channel, coded};
    end

    // Internal scan engine, timed in system clocks that stand in for the
    // on-chip oscillator; the spread of that oscillator is not modelled.
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_r <= ST_IDLE;
            timer_r <= 8'h00;
            scan_ch_r <= 4'h0;
            push_r <= 1'b0;
            eoc_n <= 1'b1;
            software_convert <= 1'b0;
            analog_awake <= 1'b0;
        end else begin
            push_r <= 1'b0;
            if (cs_fall | cnv_fall)
                eoc_n <= 1'b1;
            if (cmd_done & ~cmd_r[`CMD_TARGET_BIT] & (bits_r >= `SOFTWARE_CONVERT_HOLD_BITS))
                software_convert <= cmd_r[`CMD_SOFTWARE_CONVERT_BIT];
            case (state_r)
                ST_IDLE: begin
                    analog_awake <= 1'b0;
                    scan_ch_r <= 4'h0;
                    if (internal_mode & cnv_rise & cs_s_r[1]) begin
                        state_r <= ST_CONV;
                        analog_awake <= 1'b1;
                        timer_r <= CONV_CYC[7:0];
                    end else if (internal_mode & (software_convert | sw_take) & cs_rise) begin
                        state_r <= ST_DELAY;
                        timer_r <= SOFTWARE_CONVERT_CYC[7:0];
                    end
                end
                ST_DELAY: begin
                    timer_r <= timer_r - 8'h01;
                    if (timer_r == 8'h01) begin
                        state_r <= ST_CONV;
                        analog_awake <= 1'b1;
                        timer_r <= CONV_CYC[7:0];
                    end
                end
                ST_CONV: begin
                    timer_r <= timer_r - 8'h01;
                    if (timer_r == 8'h01) begin
                        push_r <= 1'b1;
                        timer_r <= CONV_CYC[7:0];
                        if (scan_ch_r == chan_r) begin
                            state_r <= ST_IDLE;
                            analog_awake <= 1'b0;
                            eoc_n <= 1'b0;
                            software_convert <= 1'b0;
                        end else begin
                            scan_ch_r <= scan_ch_r + 4'h1;
                        end
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // Analog core handshake: channel steering, sample strobe, common reference.
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            conv_channel <= 4'h0;
            sample_strobe <= 1'b0;
            common_reference <= 1'b0;
            fifo_count <= 4'h0;
        end else begin
            conv_channel <= internal_mode ? scan_ch_r : chan_r;
            sample_strobe <= cs_fall
                | ((state_r == ST_CONV) & (timer_r == CONV_CYC[7:0]));
            common_reference <= |pdiff_r;
            fifo_count <= fifo_full ? 4'hF : cnt_r[3:0];
        end
    end
endmodule

/* hw/adc_scan_map.vh */
`ifndef ADC_SCAN_MAP_VH
`define ADC_SCAN_MAP_VH
// Command word layout.
`define CMD_TARGET_BIT 15
`define CMD_SCAN_HI 14
`define CMD_SCAN_LO 11
`define CMD_CHAN_HI 10
`define CMD_CHAN_LO 7
`define CMD_RESET_HI 6
`define CMD_RESET_LO 5
`define CMD_TAG_BIT 2
`define CMD_SOFTWARE_CONVERT_BIT 1
`define CMD_SEL_HI 14
`define CMD_SEL_LO 11
`define CMD_DATA_HI 10
`define CMD_DATA_LO 3
`define CMD_PDIFF_HI 2
`define CMD_PDIFF_LO 1
// Configuration targets.
`define SEL_UNIPOLAR 4'h1
`define SEL_BIPOLAR 4'h2
// Scan modes and the soft reset code.
`define SCAN_MANUAL 4'h1
`define SCAN_STD_INT 4'h3
`define SOFT_RESET_CODE 2'h2
// Reset values.
`define RST_SCAN 4'h1
`define RST_CHAN 4'h0
`define RST_PAIRS 8'h00
`define RST_PDIFF 2'h0
// Timing.
`define WORD_BITS 5'h10
`define SOFTWARE_CONVERT_HOLD_BITS 5'h11
`define SYS_PERIOD_PS 20000
`define OSC_PERIOD_PS 25000
`define CONV_OSC_CYCLES 16
`define SOFTWARE_CONVERT_DELAY_NS 100
`define CONV_SYS_CYCLES ((`CONV_OSC_CYCLES * `OSC_PERIOD_PS + `SYS_PERIOD_PS - 1) / `SYS_PERIOD_PS)
`define SOFTWARE_CONVERT_SYS_CYCLES ((`SOFTWARE_CONVERT_DELAY_NS * 1000 + `SYS_PERIOD_PS - 1) / `SYS_PERIOD_PS)
`define FIFO_DEPTH 16
`endif

/* tb/adc_scan_monitor.sv */
`timescale 1ns/10ps
module adc_scan_monitor (
    input wire clk_sys,
    input wire rst,
    input wire sclk,
    input wire cs_n,
    input wire din,
    input wire conversion_start_n,
    input wire [11:0] analog_code,
    input wire analog_negative,
    input wire dout,
    input wire dout_oe,
    input wire eoc_n,
    input wire sample_strobe,
    input wire [3:0] conv_channel,
    input wire analog_awake,
    input wire common_reference,
    input wire software_convert,
    input wire channel_tag_enable,
    input wire [3:0] fifo_count
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    // Both start pins quiet long enough for the synchronisers to settle.
    sequence pins_quiet;
        (cs_n && conversion_start_n) [*6];
    endsequence
    // The software start waits out its delay before the core wakes.
    sequence sw_delay;
        (!analog_awake) [*4];
    endsequence
    chk_oe_idle: assert property (cs_n [*4] |-> !dout_oe)
        else $error("serial output driven while deselected");
    chk_strobe_fall: assert property ($fell(cs_n) |-> ##[2:6] sample_strobe)
        else $error("no sample after select fall");
    chk_strobe_pulse: assert property (sample_strobe |=> !sample_strobe)
        else $error("sample strobe longer than one cycle");
    chk_eoc_hold: assert property (pins_quiet ##0 !eoc_n |=> !eoc_n)
        else $error("end of conversion released without a falling pin");
    chk_eoc_clear: assert property ($fell(cs_n) || $fell(conversion_start_n) |-> ##[1:6] eoc_n)
        else $error("end of conversion not released");
    chk_scan_done: assert property ($fell(analog_awake) |-> ##[0:8] !eoc_n)
        else $error("scan ended without end of conversion");
    chk_sw_start: assert property ($rose(software_convert) |-> sw_delay ##[1:8] analog_awake)
        else $error("software start not delayed or missing");
    chk_sw_clear: assert property ($fell(analog_awake) |-> ##[0:6] !software_convert)
        else $error("software convert bit not cleared");
    chk_dout_steady: assert property (dout_oe && $past(dout_oe) && $past(sclk, 2)
        && $past(sclk, 3) && $past(sclk, 4) |-> $stable(dout))
        else $error("serial output changed without a clock fall");
endmodule
bind adc_serial_scan_control adc_scan_monitor adc_scan_monitor_i (.*);

/* tb/spi_master_model.sv */
`timescale 1ns/10ps
module spi_master_model (
    output logic sclk,
    output logic cs_n,
    output logic din,
    input wire logic dout
);
    // The clock idles high between frames.
    initial begin
        sclk = 1'b1;
        cs_n = 1'b1;
        din = 1'b0;
    end
    // Bits change on the falling clock; the first 16 rising edges sample the reply.
    task automatic frame(input logic [15:0] cmd, input int nbits, output logic [15:0] rd);
        rd = 16'h0000;
        cs_n = 1'b0;
        for (int i = 0; i < nbits; i++) begin
            #80 sclk = 1'b0;
            din = (i < 16) ? cmd[15 - i] : 1'b0;
            #80 sclk = 1'b1;
            if (i < 16) rd = {rd[14:0], dout};
        end
        #80 cs_n = 1'b1;
        din = ~din; // A released line must not keep its last value.
        #400;
    endtask
endmodule

/* tb/adc_serial_scan_control_tb_top.sv */
`timescale 1ns/10ps
module adc_serial_scan_control_tb_top;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic conversion_start_n = 1'b1;
    logic [11:0] analog_code = 12'hA5C;
    logic analog_negative = 1'b0;
    wire sclk, cs_n, din, dout, dout_oe, eoc_n, sample_strobe, analog_awake;
    wire common_reference, software_convert, channel_tag_enable;
    wire [3:0] conv_channel, fifo_count;
    logic [15:0] rd;
    int n;
    int err_total = 0;
    int compares = 0;
    // Free-running 50 MHz system clock.
    always #10 clk_sys = ~clk_sys;
    adc_serial_scan_control adc_serial_scan_control_i (.clk_sys(clk_sys), .rst(rst),
        .sclk(sclk), .cs_n(cs_n), .din(din), .conversion_start_n(conversion_start_n),
        .analog_code(analog_code), .analog_negative(analog_negative), .dout(dout),
        .dout_oe(dout_oe), .eoc_n(eoc_n), .sample_strobe(sample_strobe),
        .conv_channel(conv_channel), .analog_awake(analog_awake),
        .common_reference(common_reference), .software_convert(software_convert),
        .channel_tag_enable(channel_tag_enable), .fifo_count(fifo_count));
    spi_master_model spi_master_model_i (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout));
    task automatic final_report;
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic fr(input logic [15:0] cmd, input int bits);
        @(negedge clk_sys);
        spi_master_model_i.frame(cmd, bits, rd);
    endtask
    // Bounded wait; a hang is reported and ends the run.
    task automatic wait_eoc;
        n = 0;
        while (eoc_n !== 1'b0 && n < 1000) begin
            @(negedge clk_sys);
            n++;
        end
        if (n == 1000) begin
            err_total++;
            $display("[FAIL] %0t no end of conversion", $time);
            final_report();
        end
        // The FIFO count trails the end-of-conversion edge by two cycles.
        repeat (4) @(negedge clk_sys);
    endtask
    // The start pulse lasts two cycles, far above the minimum.
    task automatic start_scan;
        @(negedge clk_sys) conversion_start_n = 1'b0;
        @(negedge clk_sys) @(negedge clk_sys) conversion_start_n = 1'b1;
        repeat (8) @(negedge clk_sys);
        wait_eoc();
        n = n + 8;
    endtask
    task automatic t_reset;
        chk(16'(eoc_n), 16'h0001);
        chk(16'(dout_oe), 16'h0000);
        chk(16'(fifo_count), 16'h0000);
        $display("reset test done");
    endtask
    task automatic t_manual;
        fr(16'h0A84, 16);
        fr(16'h0A84, 16);
        fr(16'h0A84, 16);
        chk(rd, 16'h5A5C);
        chk(16'(conv_channel), 16'h0005);
        analog_negative = 1'b1;
        fr(16'h0A84, 16);
        chk(rd, 16'h5A5C);
        analog_negative = 1'b0;
        fr(16'h0A80, 16);
        chk(rd, 16'h5000);
        fr(16'h0A80, 16);
        chk(rd, 16'h52E0);
        fr(16'h9020, 16);
        fr(16'h0A84, 16);
        fr(16'h0A84, 16);
        chk(rd, 16'h525C);
        fr(16'h0A80, 8);
        chk(16'(channel_tag_enable), 16'h0001);
        $display("manual test done");
    endtask
    task automatic t_internal;
        fr(16'h8806, 16);
        chk(16'(common_reference), 16'h0001);
        fr(16'h0040, 16);
        chk(16'(common_reference), 16'h0000);
        fr(16'h1904, 16);
        start_scan();
        chk(16'(n > 55 && n < 80), 16'h0001);
        chk(16'(fifo_count), 16'h0003);
        chk(16'(analog_awake), 16'h0000);
        repeat (20) @(negedge clk_sys);
        chk(16'(eoc_n), 16'h0000);
        for (int c = 0; c < 3; c++) begin
            fr(16'h1904, 16);
            chk(rd, {4'(c), 12'hA5C});
        end
        chk(16'(eoc_n), 16'h0001);
        fr(16'h1904, 16);
        chk(rd, 16'h0000);
        $display("internal test done");
    endtask
    task automatic t_overflow;
        fr(16'h1F84, 16);
        start_scan();
        analog_code = 12'h3C1;
        start_scan();
        chk(16'(fifo_count), 16'h000F);
        fr(16'h1F84, 16);
        chk(rd, 16'h03C1);
        fr(16'h0040, 16);
        chk(16'(fifo_count), 16'h0000);
        $display("overflow test done");
    endtask
    task automatic t_software_convert;
        fr(16'h1806, 16);
        repeat (40) @(negedge clk_sys);
        chk(16'(fifo_count), 16'h0000);
        fr(16'h1806, 17);
        wait_eoc();
        chk(16'(fifo_count), 16'h0001);
        chk(16'(software_convert), 16'h0000);
        $display("software convert test done");
    endtask
    initial begin
        repeat (3) @(negedge clk_sys);
        rst = 1'b0;
        repeat (4) @(negedge clk_sys);
        t_reset();
        t_manual();
        t_internal();
        t_overflow();
        t_software_convert();
        final_report();
    end
endmodule
